/* core/test_console_interp.v */
`timescale 1ns/1ps
`default_nettype none
`include "tmci_defs.vh"
// Function
// - Base variant: 202 plus five digits loads pending transmit base code.
// - Base variant: 201 plus five digits loads receive code and retunes.
// - Codes apply only on valid receive entry; lone transmit entry ignored.
// - Ten short-form memories 0..9 hold command strings.
// - Key with function 130+n replays memory n as if dialled.
// - Programmer writes memory index, length and digits; key functions fixed at 130+n.
// - Memories must be programmed before key tests; empty memory undefined.
// - Channel variant: 201 plus three digits tunes speech channel.
// - Channel variant: 202 plus three digits selects auxiliary data channel.
// - Channel commands only accepted in test mode.
// - Channel variant: 300001 starts continuous 1200Hz tone.
// - Channel variant: 300002 starts continuous 1800Hz tone.
// - 300003 encodes 101 pattern; 300005 sends five-tone paging.
// - 300000 stops all tone output.
// - Tones output only while transmitter keyed.
// - Test mode entered when alert input low at power-up.
// - Power-up fault sounds 400Hz, 150ms on/off, for 5 seconds.
// - Signalling processor fault sounds same timed alert.
// - Unlocked synthesiser repeats alert until lock achieved.
// - Control processor not running: no alert tone.
// - Base variant: 3000000x selects 1200, 1800, 101 or no tone.
module test_console_interp #(
   parameter CHANNEL_VARIANT = 0,
   parameter ALERT_CYC = (`CLK_HZ / 1000) * `ALERT_MS,
   parameter GATE_CYC = (`CLK_HZ / 1000) * `GATE_MS,
   parameter TONE_HALF_CYC = `CLK_HZ / (2 * `ALERT_HZ)
) (
   input wire CLK_SYS,
   input wire RESET,
   input wire DIGIT_VALID,
   input wire [3:0] DIGIT,
   input wire KEY_VALID,
   input wire [7:0] KEY_FUNC,
   input wire SF_WE,
   input wire [3:0] SF_INDEX,
   input wire [3:0] SF_LEN,
   input wire [31:0] SF_DIGITS,
   input wire PRESS_TO_TALK,
   input wire EXT_ALERT_N,
   input wire CFG_MISSING,
   input wire CONSOLE_FAIL,
   input wire SIG_CPU_DOWN,
   input wire SIG_CPU_FAULT,
   input wire SYNTH_UNLOCKED,
   input wire CTRL_CPU_RUN,
   output wire BUSY,
   output reg TEST_MODE,
   output reg [19:0] RX_BASE_CODE,
   output reg [19:0] TX_BASE_CODE,
   output reg RETUNE,
   output reg [11:0] CHANNEL,
   output reg AUX_DATA_ROUTE,
   output reg [2:0] TONE_MODE,
   output reg TONE_ENABLE,
   output reg ALERT_TONE
);
   localparam ST_IDLE = 2'h0;
   localparam ST_REPLAY = 2'h1;
   localparam ST_DECODE = 2'h2;

   reg [1:0] state_ff;
   reg [31:0] buf_ff;
   reg [3:0] cnt_ff;
   reg [31:0] sf_mem_ff [0:9];
   reg [3:0] sf_len_ff [0:9];
   reg [3:0] rp_idx_ff;
   reg [3:0] rp_pos_ff;
   reg [19:0] tx_pend_ff;
   reg pwr_done_ff;
   reg [2:0] tone_sel_ff;
   reg [31:0] alert_cnt_ff;
   reg [31:0] gate_cnt_ff;
   reg [15:0] sq_cnt_ff;
   reg gate_on_ff;
   reg alert_timed_ff;
   reg sq_ff;
   wire [7:0] key_off;
   wire [3:0] key_idx;
   wire key_is_sf;
   wire [3:0] rp_digit;
   wire in_digit;
   wire [3:0] in_val;
   wire alert_req;

   // Top digit of an n-digit left-aligned buffer sits at nibble 7
   function [3:0] nib;
      input [31:0] v;
      input [3:0] p;
      begin
         nib = v[p*4 +: 4];
      end
   endfunction

   // Offset from the short-form base; below base wraps high and is refused
   assign key_off = KEY_FUNC - `KEY_SF_BASE;
   assign key_idx = key_off[3:0];
   assign key_is_sf = (KEY_FUNC >= `KEY_SF_BASE) &&
      (key_off < {4'h0, `SF_COUNT});
   assign rp_digit = nib(sf_mem_ff[rp_idx_ff], 4'h7 - rp_pos_ff);
   assign BUSY = (state_ff != ST_IDLE);
   assign in_digit = (state_ff == ST_IDLE && DIGIT_VALID) ||
      (state_ff == ST_REPLAY);
   assign in_val = (state_ff == ST_REPLAY) ?
      ((rp_pos_ff == sf_len_ff[rp_idx_ff]) ? `DIG_HASH : rp_digit) : DIGIT;
   assign alert_req = SYNTH_UNLOCKED || alert_timed_ff;

   integer i;
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         for (i = 0; i < `SF_COUNT_INT; i = i + 1) begin
            sf_mem_ff[i] <= 32'h0;
            sf_len_ff[i] <= 4'h0;
         end
      end else if (SF_WE && SF_INDEX < `SF_COUNT) begin
         sf_mem_ff[SF_INDEX] <= SF_DIGITS;
         sf_len_ff[SF_INDEX] <= SF_LEN;
      end
   end

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         state_ff <= ST_IDLE;
         buf_ff <= 32'h0;
         cnt_ff <= 4'h0;
         rp_idx_ff <= 4'h0;
         rp_pos_ff <= 4'h0;
         tx_pend_ff <= 20'h0;
         RX_BASE_CODE <= 20'h0;
         TX_BASE_CODE <= 20'h0;
         RETUNE <= 1'b0;
         CHANNEL <= 12'h0;
         AUX_DATA_ROUTE <= 1'b0;
         tone_sel_ff <= `TONE_OFF;
         pwr_done_ff <= 1'b0;
         TEST_MODE <= 1'b0;
      end else begin
         RETUNE <= 1'b0;
         if (!pwr_done_ff) begin
            pwr_done_ff <= 1'b1;
            TEST_MODE <= ~EXT_ALERT_N;
         end
         if (state_ff == ST_IDLE && KEY_VALID && !DIGIT_VALID &&
             key_is_sf) begin
            state_ff <= ST_REPLAY;
            rp_idx_ff <= key_idx;
            rp_pos_ff <= 4'h0;
            cnt_ff <= 4'h0;
         end else if (in_digit) begin
            if (state_ff == ST_REPLAY)
               rp_pos_ff <= rp_pos_ff + 4'h1;
            if (in_val == `DIG_HASH) begin
               state_ff <= ST_DECODE;
            end else if (cnt_ff < `BUF_DIGITS) begin
               buf_ff <= {buf_ff[27:0], in_val};
               cnt_ff <= cnt_ff + 4'h1;
            end
         end else if (state_ff == ST_DECODE) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            buf_ff <= 32'h0;
            if (TEST_MODE && CHANNEL_VARIANT != 0 &&
                cnt_ff == `CMD_LEN_CH) begin
               if (buf_ff[23:12] == `PFX_RX) begin
                  CHANNEL <= buf_ff[11:0];
                  AUX_DATA_ROUTE <= 1'b0;
                  RETUNE <= 1'b1;
               end else if (buf_ff[23:12] == `PFX_TX) begin
                  CHANNEL <= buf_ff[11:0];
                  AUX_DATA_ROUTE <= 1'b1;
                  RETUNE <= 1'b1;
               end else if (buf_ff[23:12] == `PFX_TONE &&
                  buf_ff[11:4] == 8'h0 && (buf_ff[3:0] <= 4'h3 ||
                  buf_ff[3:0] == 4'h5))
                  tone_sel_ff <= buf_ff[2:0];
            end
            if (TEST_MODE && CHANNEL_VARIANT == 0 &&
                cnt_ff == `CMD_LEN_BASE) begin
               if (buf_ff[31:20] == `PFX_TX)
                  tx_pend_ff <= buf_ff[19:0];
               else if (buf_ff[31:20] == `PFX_RX) begin
                  RX_BASE_CODE <= buf_ff[19:0];
                  TX_BASE_CODE <= tx_pend_ff;
                  RETUNE <= 1'b1;
               end else if (buf_ff[31:20] == `PFX_TONE &&
                  buf_ff[19:4] == 16'h0 && buf_ff[3:0] <= 4'h3)
                  tone_sel_ff <= buf_ff[2:0];
            end
         end
      end
   end

   // Tone mode selected holds, but drives only while keyed
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         TONE_MODE <= `TONE_OFF;
         TONE_ENABLE <= 1'b0;
      end else begin
         TONE_MODE <= PRESS_TO_TALK ? tone_sel_ff : `TONE_OFF;
         TONE_ENABLE <= PRESS_TO_TALK && tone_sel_ff != `TONE_OFF;
      end
   end

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         alert_timed_ff <= 1'b0;
         alert_cnt_ff <= 32'h0;
         gate_cnt_ff <= 32'h0;
         gate_on_ff <= 1'b1;
         sq_cnt_ff <= 16'h0;
         sq_ff <= 1'b0;
         ALERT_TONE <= 1'b0;
      end else begin
         if (!pwr_done_ff && (CFG_MISSING || CONSOLE_FAIL || SIG_CPU_DOWN))
            alert_timed_ff <= 1'b1;
         else if (SIG_CPU_FAULT && !alert_timed_ff) begin
            alert_timed_ff <= 1'b1;
            alert_cnt_ff <= 32'h0;
         end else if (alert_timed_ff) begin
            if (alert_cnt_ff == ALERT_CYC - 1)
               alert_timed_ff <= 1'b0;
            else
               alert_cnt_ff <= alert_cnt_ff + 32'h1;
         end
         if (!alert_req || gate_cnt_ff == GATE_CYC - 1) begin
            gate_cnt_ff <= 32'h0;
            gate_on_ff <= alert_req ? ~gate_on_ff : 1'b1;
         end else
            gate_cnt_ff <= gate_cnt_ff + 32'h1;
         if (sq_cnt_ff == TONE_HALF_CYC - 1) begin
            sq_cnt_ff <= 16'h0;
            sq_ff <= ~sq_ff;
         end else
            sq_cnt_ff <= sq_cnt_ff + 16'h1;
         // No control processor means silence
         ALERT_TONE <= CTRL_CPU_RUN && alert_req && gate_on_ff && sq_ff;
      end
   end
endmodule // test_console_interp
`default_nettype wire

/* pkg/tmci_defs.vh */
`ifndef TMCI_DEFS_VH
`define TMCI_DEFS_VH
// Digit codes on the console digit bus
`define DIG_HASH 4'hb
// Command prefixes
`define PFX_RX 12'h201
`define PFX_TX 12'h202
`define PFX_TONE 12'h300
// Short-form key function base value
`define KEY_SF_BASE 8'h82
// Tone mode codes
`define TONE_OFF 3'h0
`define TONE_1200 3'h1
`define TONE_1800 3'h2
`define TONE_101 3'h3
`define TONE_PAGE 3'h5
// Alert timing and digit buffer depth
`define CLK_HZ 20000000
`define ALERT_HZ 400
`define GATE_MS 150
`define ALERT_MS 5000
`define BUF_DIGITS 4'h8
// Command lengths in digits, hash excluded
`define CMD_LEN_CH 4'h6
`define CMD_LEN_BASE 4'h8
// Number of short-form memories
`define SF_COUNT 4'ha
`define SF_COUNT_INT 10
`endif

/* sim/console_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmci_defs.vh"
module console_model (
   input wire logic clk,
   input wire logic busy,
   output logic dv,
   output logic [3:0] dg,
   output logic kv,
   output logic [7:0] kf,
   output logic we,
   output logic [3:0] si,
   output logic [3:0] sl,
   output logic [31:0] sd
);
   initial {dv, dg, kv, kf, we, si, sl, sd} = '0;
   task automatic put(input logic [3:0] d);
      @(negedge clk);
      while (busy) @(negedge clk);
      dv = 1'b1;
      dg = d;
      @(negedge clk);
      dv = 1'b0;
      dg = ~d; // Released bus must not echo the digit
   endtask
   task automatic settle;
      repeat (3) @(negedge clk);
      for (int k = 0; k < 40 && busy; k++) @(negedge clk);
      // Tone mode lags the decode by one cycle
      repeat (2) @(negedge clk);
   endtask
   task automatic dial(input logic [31:0] s, input int n);
      for (int i = 0; i < n; i++) put(s[31-4*i -: 4]);
      put(`DIG_HASH);
      settle();
   endtask
   task automatic key(input logic [7:0] f);
      @(negedge clk);
      while (busy) @(negedge clk);
      kv = 1'b1;
      kf = f;
      @(negedge clk);
      kv = 1'b0;
      kf = ~f;
      settle();
   endtask
   task automatic prog(input logic [3:0] i, input logic [3:0] n,
      input logic [31:0] d);
      @(negedge clk);
      {we, si, sl, sd} = {1'b1, i, n, d};
      @(negedge clk);
      {we, si, sd} = {1'b0, ~i, ~d};
   endtask
endmodule // console_model
`default_nettype wire

/* sim/test_mode_console_command_interpreter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mode_console_command_interpreter_test;
   logic clk, rst, press_to_talk, alert_n, cfg_miss, unlocked, cpu_run;
   logic con_fail, cpu_fault;
   wire aux2;
   wire [11:0] chan2;
   wire [2:0] tone2;
   int retune_cnt = 0;
   logic [3:0] cc [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h0};
   wire busy, tmode, retune, aux, t_en, alert, dv, kv, we;
   wire [19:0] rx, tx;
   wire [11:0] chan;
   wire [2:0] tone;
   wire [3:0] dg, si, sl;
   wire [7:0] kf;
   wire [31:0] sd;
   int num_errors = 0;
   int cmp_count = 0;
   logic [3:0] tc [3] = '{4'h2, 4'h3, 4'h0};
   console_model console_model_i (.clk, .busy, .dv, .dg, .kv, .kf, .we,
      .si, .sl, .sd);
   test_console_interp #(.ALERT_CYC(200), .GATE_CYC(20), .TONE_HALF_CYC(2))
      test_console_interp_i (
      .CLK_SYS(clk), .RESET(rst), .DIGIT_VALID(dv), .DIGIT(dg),
      .KEY_VALID(kv), .KEY_FUNC(kf), .SF_WE(we), .SF_INDEX(si), .SF_LEN(sl),
      .SF_DIGITS(sd), .PRESS_TO_TALK(press_to_talk), .EXT_ALERT_N(alert_n),
      .CFG_MISSING(cfg_miss), .CONSOLE_FAIL(con_fail), .SIG_CPU_DOWN(1'b0),
      .SIG_CPU_FAULT(cpu_fault), .SYNTH_UNLOCKED(unlocked),
      .CTRL_CPU_RUN(cpu_run),
      .BUSY(busy), .TEST_MODE(tmode), .RX_BASE_CODE(rx), .TX_BASE_CODE(tx),
      .RETUNE(retune), .CHANNEL(chan), .AUX_DATA_ROUTE(aux), .TONE_MODE(tone),
      .TONE_ENABLE(t_en), .ALERT_TONE(alert));
   // Channel variant sees the same digit stream
   test_console_interp #(.CHANNEL_VARIANT(1), .ALERT_CYC(200), .GATE_CYC(20),
      .TONE_HALF_CYC(2)) test_console_interp_ch_i (
      .CLK_SYS(clk), .RESET(rst), .DIGIT_VALID(dv), .DIGIT(dg),
      .KEY_VALID(kv), .KEY_FUNC(kf), .SF_WE(we), .SF_INDEX(si), .SF_LEN(sl),
      .SF_DIGITS(sd), .PRESS_TO_TALK(press_to_talk), .EXT_ALERT_N(alert_n),
      .CFG_MISSING(cfg_miss), .CONSOLE_FAIL(con_fail), .SIG_CPU_DOWN(1'b0),
      .SIG_CPU_FAULT(cpu_fault), .SYNTH_UNLOCKED(unlocked),
      .CTRL_CPU_RUN(cpu_run),
      .BUSY(), .TEST_MODE(), .RX_BASE_CODE(), .TX_BASE_CODE(),
      .RETUNE(), .CHANNEL(chan2), .AUX_DATA_ROUTE(aux2), .TONE_MODE(tone2),
      .TONE_ENABLE(), .ALERT_TONE());
   always @(posedge clk) begin
      if (retune === 1'b1)
         retune_cnt++;
   end
   task automatic count_alert(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (alert === 1'b1)
            c++;
      end
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic power_up(input logic test);
      rst = 1'b1;
      alert_n = ~test;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk(20'(tmode), 20'(test));
   endtask
   task automatic t_alert;
      int c;
      cpu_run = 1'b0;
      count_alert(30, c);
      chk(20'(c), 20'h0);
      cpu_run = 1'b1;
      count_alert(100, c);
      chk(20'(c > 0), 20'h1);
      repeat (150) @(negedge clk);
      count_alert(40, c);
      chk(20'(c), 20'h0);
      cpu_fault = 1'b1;
      @(negedge clk);
      cpu_fault = 1'b0;
      count_alert(100, c);
      chk(20'(c > 0), 20'h1);
      repeat (150) @(negedge clk);
      count_alert(40, c);
      chk(20'(c), 20'h0);
      unlocked = 1'b1;
      count_alert(100, c);
      chk(20'(c > 0), 20'h1);
      unlocked = 1'b0;
      repeat (3) @(negedge clk);
      count_alert(40, c);
      chk(20'(c), 20'h0);
      $display("alert test done");
   endtask
   task automatic t_codes;
      console_model_i.dial(32'h20230720, 8);
      chk(tx, 20'h0);
      console_model_i.dial(32'h20112345, 8);
      chk(rx, 20'h12345);
      chk(tx, 20'h30720);
      console_model_i.dial(32'h20154320, 7);
      chk(rx, 20'h12345);
      console_model_i.prog(4'h3, 4'h8, 32'h20154321);
      console_model_i.key(8'h85);
      chk(rx, 20'h54321);
      chk(20'(retune_cnt), 20'h2);
      $display("code test done");
   endtask
   task automatic t_tones;
      press_to_talk = 1'b1;
      console_model_i.prog(4'h0, 4'h8, 32'h30000001);
      console_model_i.key(8'h82);
      chk(20'(tone), 20'h1);
      chk(20'(t_en), 20'h1);
      for (int i = 0; i < 3; i++) begin
         console_model_i.dial({28'h3000000, tc[i]}, 8);
         chk(20'(tone), 20'(tc[i]));
      end
      for (int i = 0; i < 5; i++) begin
         console_model_i.dial({20'h30000, cc[i], 8'h00}, 6);
         chk(20'(tone2), 20'(cc[i]));
      end
      console_model_i.dial(32'h20112300, 6);
      chk(20'(chan2), 20'h123);
      chk(20'(aux2), 20'h0);
      console_model_i.dial(32'h20245600, 6);
      chk(20'(chan2), 20'h456);
      chk(20'(aux2), 20'h1);
      console_model_i.dial(32'h30000001, 8);
      press_to_talk = 1'b0;
      repeat (3) @(negedge clk);
      chk(20'(tone), 20'h0);
      chk(20'(t_en), 20'h0);
      power_up(1'b0);
      console_model_i.dial(32'h20112345, 8);
      chk(rx, 20'h0);
      chk(20'(retune_cnt), 20'h2);
      $display("tone test done");
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {press_to_talk, cfg_miss, unlocked, cpu_run} = 4'h5;
      {con_fail, cpu_fault} = 2'h0;
      power_up(1'b1);
      t_alert();
      t_codes();
      t_tones();
      print_verdict();
   end
   initial begin
      #1000000;
      num_errors++;
      print_verdict();
   end
endmodule // test_mode_console_command_interpreter_test
`default_nettype wire

/* sim/tmci_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tmci_checker (
   input wire CLK_SYS,
   input wire RESET,
   input wire PRESS_TO_TALK,
   input wire CTRL_CPU_RUN,
   input wire TEST_MODE,
   input wire RETUNE,
   input wire [19:0] RX_BASE_CODE,
   input wire [19:0] TX_BASE_CODE,
   input wire [2:0] TONE_MODE,
   input wire ALERT_TONE
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   sequence run_2;
      !RESET [*2];
   endsequence
   sequence ptt_off_2;
      !PRESS_TO_TALK [*2];
   endsequence
   AST_MODE_LATCH: assert property (run_2 |=> $stable(TEST_MODE))
      else $error("test mode moved after power-up");
   AST_RX_RETUNE: assert property ($changed(RX_BASE_CODE) |-> RETUNE)
      else $error("rx code changed without retune");
   AST_TX_WITH_RX: assert property ($changed(TX_BASE_CODE) |-> RETUNE)
      else $error("tx code applied without rx entry");
   AST_RETUNE_PULSE: assert property (RETUNE |=> !RETUNE)
      else $error("retune longer than one cycle");
   AST_TEST_ONLY: assert property (!TEST_MODE |-> !RETUNE)
      else $error("retune outside test mode");
   AST_TONE_KEYED: assert property (ptt_off_2 |-> TONE_MODE == 3'h0)
      else $error("tone while not keyed");
   AST_NO_ALERT: assert property (!CTRL_CPU_RUN [*2] |-> !ALERT_TONE)
      else $error("alert with control cpu halted");
   AST_TONE_SET: assert property (TONE_MODE inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5})
      else $error("illegal tone mode");
endmodule // tmci_checker
bind test_console_interp tmci_checker tmci_checker_i (.CLK_SYS, .RESET,
   .PRESS_TO_TALK, .CTRL_CPU_RUN, .TEST_MODE, .RETUNE, .RX_BASE_CODE,
   .TX_BASE_CODE, .TONE_MODE, .ALERT_TONE);
`default_nettype wire
